// ### rtl/bsc_pkg.sv
// shared constants and types of the burst sram cycle control block
// assumes a single 50 MHz core clock domain
package bsc_pkg;
  localparam int unsigned ADDR_W_DEF  = 16;
  localparam int unsigned BYTE_W_DEF  = 9;
  localparam int unsigned NUM_BYTES   = 2;
  localparam int unsigned LSB_W       = 2;
  localparam logic [1:0]  CNT_RST     = 2'h0;
  localparam logic [1:0]  CNT_STEP    = 2'h1;
  localparam logic [1:0]  BE_NONE     = 2'h0;
  localparam logic [1:0]  BE_ALL      = 2'h3;
  localparam int unsigned LO_BYTE_POS = 0;
  localparam int unsigned HI_BYTE_POS = 1;

  // gray coded along deselect -> read -> write
  typedef enum logic [1:0] {
    BSC_DESEL = 2'h0,
    BSC_READ  = 2'h1,
    BSC_WRITE = 2'h3
  } bsc_cyc_t;

  localparam bsc_cyc_t CYC_RST = BSC_DESEL;
endpackage

// ### rtl/bsc_core.sv
// cycle control and storage array of a synchronous flow-through burst sram
// assumes all inputs except the output enable and burst order are synchronous to CORE_CLK_I
`timescale 1ns/1ps

// Function
// - low depth enable active when sampled low
// - global write writes both bytes
// - gated write writes only selected bytes
// - deselect and float on disabled strobe starts
// - enabled strobes load external address, start cycle
// - write when global or gate plus byte low, except processor strobe starts, which always read
// - output enable acts unsampled on data drivers
// - linear order counts upward modulo four
// - interleaved order xors start with count
// - processor strobe ignored while primary disabled
// - address, data, controls captured on rising edge
module bsc_core #(
  parameter int unsigned ADDR_W = bsc_pkg::ADDR_W_DEF,
  parameter int unsigned BYTE_W = bsc_pkg::BYTE_W_DEF
) (
  input  wire logic                             CORE_CLK_I,
  input  wire logic                             RSTN_I,
  input  wire logic                             CLK_EN_I,
  input  wire logic                             PRIMARY_CHIP_ENABLE_N_I,
  input  wire logic                             DEPTH_ENABLE_HIGH_I,
  input  wire logic                             DEPTH_ENABLE_LOW_N_I,
  input  wire logic                             PROCESSOR_ADDR_STROBE_N_I,
  input  wire logic                             CONTROLLER_ADDR_STROBE_N_I,
  input  wire logic                             BURST_STEP_N_I,
  input  wire logic                             BURST_ORDER_SELECT_I,
  input  wire logic                             GLOBAL_WRITE_N_I,
  input  wire logic                             BYTE_WRITE_GATE_N_I,
  input  wire logic                             BYTE_WRITE_LO_N_I,
  input  wire logic                             BYTE_WRITE_HI_N_I,
  input  wire logic                             OUTPUT_ENABLE_N_I,
  input  wire logic [ADDR_W-1:0]                SYNC_ADDRESS_I,
  input  wire logic [bsc_pkg::NUM_BYTES*BYTE_W-1:0] DATA_I,
  output logic      [bsc_pkg::NUM_BYTES*BYTE_W-1:0] DATA_O,
  output logic                                  DATA_OE_O,
  output bsc_pkg::bsc_cyc_t                     CYCLE_O
);
  import bsc_pkg::*;

  localparam int unsigned DATA_W = NUM_BYTES * BYTE_W;
  localparam int unsigned DEPTH  = 1 << ADDR_W;

  typedef struct packed {
    bsc_cyc_t    cyc;
    logic [ADDR_W-1:0] base;
    logic [1:0]  cnt;
  } bsc_state_t;

  bsc_state_t st_ff;
  bsc_state_t nxt_st;

  logic [DATA_W-1:0] mem [DEPTH];

  logic              all_en_c;
  logic              desel_c;
  logic              proc_go_c;
  logic              ctrl_go_c;
  logic              wr_c;
  logic [1:0]        be_c;
  logic [ADDR_W-1:0] cur_addr_c;
  logic [ADDR_W-1:0] nxt_addr_c;
  logic [1:0]        nxt_lsb_c;

  // burst address from loaded start and step count
  always_comb begin
    if (BURST_ORDER_SELECT_I) begin
      nxt_lsb_c = st_ff.base[1:0] ^ st_ff.cnt;
    end else begin
      nxt_lsb_c = 2'(st_ff.base[1:0] + st_ff.cnt);
    end
    cur_addr_c = {st_ff.base[ADDR_W-1:LSB_W], nxt_lsb_c};
  end

  always_comb begin
    all_en_c  = ~PRIMARY_CHIP_ENABLE_N_I & DEPTH_ENABLE_HIGH_I & ~DEPTH_ENABLE_LOW_N_I;
    desel_c   = (~CONTROLLER_ADDR_STROBE_N_I &
                 (PRIMARY_CHIP_ENABLE_N_I | ~DEPTH_ENABLE_HIGH_I | DEPTH_ENABLE_LOW_N_I)) |
                (~PROCESSOR_ADDR_STROBE_N_I & ~PRIMARY_CHIP_ENABLE_N_I &
                 (~DEPTH_ENABLE_HIGH_I | DEPTH_ENABLE_LOW_N_I));
    // a processor strobe with the primary enable high falls through to continue
    proc_go_c = all_en_c & ~PROCESSOR_ADDR_STROBE_N_I;
    ctrl_go_c = all_en_c & PROCESSOR_ADDR_STROBE_N_I & ~CONTROLLER_ADDR_STROBE_N_I;
    wr_c      = ~GLOBAL_WRITE_N_I |
                (~BYTE_WRITE_GATE_N_I & (~BYTE_WRITE_LO_N_I | ~BYTE_WRITE_HI_N_I));
    if (!GLOBAL_WRITE_N_I) begin
      be_c = BE_ALL;
    end else if (!BYTE_WRITE_GATE_N_I) begin
      be_c = {~BYTE_WRITE_HI_N_I, ~BYTE_WRITE_LO_N_I};
    end else begin
      be_c = BE_NONE;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    if (desel_c) begin
      nxt_st.cyc = BSC_DESEL;
    end else if (proc_go_c) begin
      nxt_st.cyc  = BSC_READ;
      nxt_st.base = SYNC_ADDRESS_I;
      nxt_st.cnt  = CNT_RST;
    end else if (ctrl_go_c) begin
      nxt_st.cyc  = wr_c ? BSC_WRITE : BSC_READ;
      nxt_st.base = SYNC_ADDRESS_I;
      nxt_st.cnt  = CNT_RST;
    end else if (st_ff.cyc != BSC_DESEL) begin
      nxt_st.cyc = wr_c ? BSC_WRITE : BSC_READ;
      if (!BURST_STEP_N_I) begin
        nxt_st.cnt = 2'(st_ff.cnt + CNT_STEP);
      end
    end
  end

  // address the new cycle will use, so a write lands at its own edge
  always_comb begin
    if (nxt_st.base == st_ff.base && nxt_st.cyc != BSC_DESEL && !proc_go_c && !ctrl_go_c) begin
      nxt_addr_c = {st_ff.base[ADDR_W-1:LSB_W],
                    BURST_ORDER_SELECT_I ? (st_ff.base[1:0] ^ nxt_st.cnt)
                                         : 2'(st_ff.base[1:0] + nxt_st.cnt)};
    end else begin
      nxt_addr_c = nxt_st.base;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      st_ff <= '{cyc: CYC_RST, base: '0, cnt: CNT_RST};
    end else if (CLK_EN_I) begin
      st_ff <= nxt_st;
    end
  end

  // array is not reset; write data is taken at the same edge as its address
  always_ff @(posedge CORE_CLK_I) begin
    if (CLK_EN_I && nxt_st.cyc == BSC_WRITE) begin
      if (be_c[LO_BYTE_POS]) begin
        mem[nxt_addr_c][BYTE_W-1:0] <= DATA_I[BYTE_W-1:0];
      end
      if (be_c[HI_BYTE_POS]) begin
        mem[nxt_addr_c][DATA_W-1:BYTE_W] <= DATA_I[DATA_W-1:BYTE_W];
      end
    end
  end

  // flow-through read and unsampled enable cannot come from a flop by nature
  always_comb begin
    DATA_O    = (st_ff.cyc == BSC_READ) ? mem[cur_addr_c] : '0;
    DATA_OE_O = (st_ff.cyc == BSC_READ) & ~OUTPUT_ENABLE_N_I;
    CYCLE_O   = st_ff.cyc;
  end

  dsel_cyc_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    CLK_EN_I && desel_c |=> st_ff.cyc == BSC_DESEL && !DATA_OE_O)
    else $error("deselect did not float the bus");

  depth_low_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    CLK_EN_I && !PRIMARY_CHIP_ENABLE_N_I && DEPTH_ENABLE_HIGH_I && DEPTH_ENABLE_LOW_N_I
    && !PROCESSOR_ADDR_STROBE_N_I |=> st_ff.cyc == BSC_DESEL)
    else $error("high low-depth enable did not deselect");

  proc_read_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    CLK_EN_I && proc_go_c |=> st_ff.cyc == BSC_READ && cur_addr_c == $past(SYNC_ADDRESS_I))
    else $error("processor strobe did not start a read");

  glob_write_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    !GLOBAL_WRITE_N_I |-> be_c == BE_ALL)
    else $error("global write missed a byte");

  byte_write_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    GLOBAL_WRITE_N_I && !BYTE_WRITE_GATE_N_I |->
    be_c == {~BYTE_WRITE_HI_N_I, ~BYTE_WRITE_LO_N_I})
    else $error("gated byte write enables wrong");

  read_class_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    CLK_EN_I && ctrl_go_c && GLOBAL_WRITE_N_I && BYTE_WRITE_GATE_N_I
    |=> st_ff.cyc == BSC_READ)
    else $error("cycle without write controls not a read");

  oe_async_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    DATA_OE_O == (st_ff.cyc == BSC_READ && !OUTPUT_ENABLE_N_I))
    else $error("driver enable not following output enable");

  lin_burst_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    CLK_EN_I && !BURST_ORDER_SELECT_I && st_ff.cyc != BSC_DESEL && !desel_c && !proc_go_c
    && !ctrl_go_c && !BURST_STEP_N_I ##1 !BURST_ORDER_SELECT_I
    |-> cur_addr_c[1:0] == 2'($past(cur_addr_c[1:0]) + 2'h1))
    else $error("linear burst step wrong");

  // successive interleaved addresses differ by 01 after an even count, by 11 after an odd one
  intl_burst_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    CLK_EN_I && BURST_ORDER_SELECT_I && st_ff.cyc != BSC_DESEL && !desel_c && !proc_go_c
    && !ctrl_go_c && !BURST_STEP_N_I ##1 BURST_ORDER_SELECT_I
    |-> (cur_addr_c[1:0] ^ $past(cur_addr_c[1:0])) == ($past(st_ff.cnt[0]) ? 2'h3 : 2'h1))
    else $error("interleaved burst address wrong");

  ign_proc_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    CLK_EN_I && !PROCESSOR_ADDR_STROBE_N_I && PRIMARY_CHIP_ENABLE_N_I
    && CONTROLLER_ADDR_STROBE_N_I |=> st_ff.base == $past(st_ff.base)
    && st_ff.cyc == ($past(st_ff.cyc) == BSC_DESEL ? BSC_DESEL : st_ff.cyc))
    else $error("processor strobe not ignored");

  hold_addr_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    CLK_EN_I && !desel_c && !proc_go_c && !ctrl_go_c && BURST_STEP_N_I
    |=> cur_addr_c == $past(cur_addr_c))
    else $error("suspended burst moved");

  flow_read_a: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    st_ff.cyc == BSC_READ |-> DATA_O == mem[cur_addr_c])
    else $error("read data not flowing from array");
endmodule

// ### verification/bsc_ctl_model.sv
// controller model: drives cycle controls, address, write data, output enable
// assumes drive is called just after a rising clock edge
`timescale 1ns/1ps
module bsc_ctl_model (
  output logic [9:0]  ctl_o,
  output logic [3:0]  addr_o,
  output logic [17:0] data_o,
  output logic        oe_n_o
);
  // no sleep mode here, so the spare pin sits low and needs no port
  // ctl msb first: pce_n deh del_n ps_n cs_n step_n gw_n gate_n lo_n hi_n
  initial begin
    ctl_o = 10'h17f;
    addr_o = 4'h0;
    data_o = 18'h0;
    oe_n_o = 1'b1;
  end
  task automatic drive(input logic [9:0] c, input logic [3:0] a, input logic [17:0] d,
                       input logic g);
    logic wr;
    wr = !c[3] || (!c[2] && !(c[1] && c[0]));
    ctl_o = c;
    addr_o = a;
    // released data lines toggle so stale data never passes for write data
    data_o = wr ? d : ~data_o;
    oe_n_o = g || wr;
  endtask
endmodule

// ### verification/tb_top.sv
// self-checking bench of the burst sram cycle control block
// assumes the controller model applies one command per clock
`timescale 1ns/1ps
module tb_top;
  import bsc_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        burst_order_select = 1'b0;
  logic        en = 1'b1;
  logic [9:0]  ctl;
  logic [3:0]  addr, base = 4'h0, cur;
  logic [17:0] din, dout;
  logic [17:0] mem [16];
  logic        oe_n, oe;
  logic [1:0]  cnt = 2'h0;
  bsc_cyc_t    cyc, cyc_exp = BSC_DESEL;
  int          err_total = 0;
  int          checked = 0;
  localparam logic [9:0] DSL [5] = '{10'h35f, 10'h03f, 10'h1bf, 10'h1df, 10'h05f};
  always #10 clk = ~clk;
  bsc_ctl_model u_ctl (.ctl_o(ctl), .addr_o(addr), .data_o(din), .oe_n_o(oe_n));
  bsc_core #(.ADDR_W(4)) u_dut (
    .CORE_CLK_I(clk), .RSTN_I(rst_n), .CLK_EN_I(en), .PRIMARY_CHIP_ENABLE_N_I(ctl[9]),
    .DEPTH_ENABLE_HIGH_I(ctl[8]), .DEPTH_ENABLE_LOW_N_I(ctl[7]),
    .PROCESSOR_ADDR_STROBE_N_I(ctl[6]), .CONTROLLER_ADDR_STROBE_N_I(ctl[5]),
    .BURST_STEP_N_I(ctl[4]), .BURST_ORDER_SELECT_I(burst_order_select), .GLOBAL_WRITE_N_I(ctl[3]),
    .BYTE_WRITE_GATE_N_I(ctl[2]), .BYTE_WRITE_LO_N_I(ctl[1]), .BYTE_WRITE_HI_N_I(ctl[0]),
    .OUTPUT_ENABLE_N_I(oe_n), .SYNC_ADDRESS_I(addr), .DATA_I(din), .DATA_O(dout),
    .DATA_OE_O(oe), .CYCLE_O(cyc));
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic go(input logic [9:0] c, input logic [3:0] a, input logic [17:0] d,
                    input logic g);
    logic ds, wr, pre;
    logic [1:0] be;
    ds = (!c[5] && (c[9] || !c[8] || c[7])) || (!c[6] && !c[9] && (!c[8] || c[7]));
    wr = !c[3] || (!c[2] && !(c[1] && c[0]));
    be = c[3] ? (c[2] ? 2'h0 : ~{c[0], c[1]}) : 2'h3;
    pre = cyc_exp == BSC_READ && !(g || wr);
    u_ctl.drive(c, a, d, g);
    #1;
    // a sampled enable would still show the old level here, before the next edge
    chk(18'(oe), 18'(pre));
    if (en && ds) cyc_exp = BSC_DESEL;
    else if (en && !c[9] && c[8] && !c[7] && (!c[6] || !c[5])) begin
      base = a;
      cnt = 2'h0;
      cyc_exp = (c[6] && wr) ? BSC_WRITE : BSC_READ;
    end else if (en && cyc_exp != BSC_DESEL) begin
      cnt = cnt + {1'b0, !c[4]};
      cyc_exp = wr ? BSC_WRITE : BSC_READ;
    end
    cur = {base[3:2], burst_order_select ? base[1:0] ^ cnt : base[1:0] + cnt};
    if (en && cyc_exp == BSC_WRITE && be[0]) mem[cur][8:0] = d[8:0];
    if (en && cyc_exp == BSC_WRITE && be[1]) mem[cur][17:9] = d[17:9];
    @(posedge clk);
    #1;
    chk(18'(cyc), 18'(cyc_exp));
    chk(dout, cyc_exp == BSC_READ ? mem[cur] : 18'h0);
    chk(18'(oe), 18'(cyc_exp == BSC_READ && !(g || wr)));
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk(18'(cyc), 18'(BSC_DESEL));
    for (int i = 0; i < 4; i++) go(i == 0 ? 10'h157 : 10'h167, 4'h1, 18'(i * 4369 + 5), 1'b1);
    for (int i = 0; i < 4; i++) go(i == 0 ? 10'h13f : 10'h16f, 4'h1, 18'h0, 1'b0);
    go(10'h17f, 4'h0, 18'h0, 1'b1);
    $display("test linear_burst done");
    go(10'h169, 4'h0, 18'h2aaaa, 1'b1);
    go(10'h17a, 4'h0, 18'h15555, 1'b1);
    go(10'h16b, 4'h0, 18'h0, 1'b0);
    go(10'h13f, 4'h1, 18'h0, 1'b0);
    go(10'h137, 4'h3, 18'h3ffff, 1'b0);
    $display("test byte_write done");
    // frozen edges: no write at 2 and no step; the next read of 2 proves the array kept its word
    en = 1'b0;
    go(10'h157, 4'h2, 18'h01234, 1'b1);
    go(10'h16f, 4'h0, 18'h0, 1'b0);
    en = 1'b1;
    $display("test clock_enable done");
    for (int i = 0; i < 5; i++) begin
      go(10'h13f, 4'h2, 18'h0, 1'b0);
      go(DSL[i], 4'h0, 18'h0, 1'b0);
      go(10'h16f, 4'h0, 18'h0, 1'b0);
    end
    go(10'h13f, 4'h2, 18'h0, 1'b0);
    go(10'h33f, 4'h5, 18'h0, 1'b0);
    $display("test deselect done");
    burst_order_select = 1'b1;
    for (int i = 0; i < 4; i++) go(i == 0 ? 10'h157 : 10'h167, 4'h6, 18'(i * 7 + 3), 1'b1);
    for (int i = 0; i < 4; i++) go(i == 0 ? 10'h13f : 10'h16f, 4'h6, 18'h0, 1'b0);
    $display("test interleaved_burst done");
    stop_test();
  end
  initial begin
    #100000;
    err_total++;
    stop_test();
  end
endmodule
